// ===== bench/tb_top.sv
// Purpose: Self-checking bench for the config space map
// Assumes: Read data one cycle after the read strobe, messages one cycle
// Notes:   Header type read from bits 23:16 of the misc word
`timescale 1ns/1ns
`default_nettype none
`include "cfg_space_defs.svh"

`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb_top;
	import cfg_space_pkg::*;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        root_port_mode = 1'b0;
	logic        user_ext_rd;
	logic [31:0] user_ext_rdata;
	msg_beat_t   msg_in = '0;
	msg_beat_t   cq_msg_out;
	msg_beat_t   port_msg_out;
	logic        msg_dropped;
	int          mismatches = 0;
	int          n_checks = 0;

	always #20 clk = ~clk;

	pcie_config_space_map dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.root_port_mode(root_port_mode), .user_ext_rd(user_ext_rd), .user_ext_rdata(user_ext_rdata),
		.msg_in(msg_in), .cq_msg_out(cq_msg_out), .port_msg_out(port_msg_out), .msg_dropped(msg_dropped));

	user_ext_model ext_u (.clk(clk), .sys_rst(sys_rst), .user_ext_rd(user_ext_rd),
		.reg_addr(reg_addr), .user_ext_rdata(user_ext_rdata));

	// ------------------------------------------------------------
	// Bus and message tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd

	task automatic send(input msg_kind_t k, output msg_beat_t cq, output msg_beat_t pt, output logic dr);
		@(posedge clk);
		msg_in <= '{valid: 1'b1, kind: k, payload: 32'h1234_0000 | 32'(k)};
		@(posedge clk);
		msg_in <= '0;
		@(negedge clk);
		cq = cq_msg_out;
		pt = port_msg_out;
		dr = msg_dropped;
	endtask : send

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_header;
		logic [31:0] d;
		rd(`OFS_FUNCTION_IDENTITY, d); `CHK("identity", 32'h0001_0002, d)
		wr(`OFS_FUNCTION_IDENTITY, 32'hFFFF_FFFF);
		rd(`OFS_FUNCTION_IDENTITY, d); `CHK("identity ro", 32'h0001_0002, d)
		rd(`OFS_CLASS_AND_REVISION, d); `CHK("class", 32'h0580_0000, d)
		wr(`OFS_STATUS_AND_COMMAND, 32'hFFFF_FFFF);
		rd(`OFS_STATUS_AND_COMMAND, d); `CHK("status cmd", 32'h0010_0547, d)
		rd(`OFS_INTERRUPT_PIN_LINE, d); `CHK("irq pin", 8'h01, d[15:8])
		rd(`OFS_RESERVED_LO, d); `CHK("rsvd 040", 32'h0000_0000, d)
		rd(`OFS_RESERVED_HI, d); `CHK("rsvd 07c", 32'h0000_0000, d)
		rd(12'h100, d); `CHK("unimpl 100", 32'h0000_0000, d)
		rd(`OFS_MSG_IRQ_PENDING, d); `CHK("pending", 32'h0000_0000, d)
	endtask : t_header

	task automatic t_chain;
		logic [31:0] d;
		logic [7:0]  ids [3] = '{8'h01, 8'h05, 8'h10};
		logic [7:0]  nxt [3] = '{8'h90, 8'hC0, 8'h00};
		rd(`OFS_CAP_LIST_POINTER, d); `CHK("cap ptr", 8'h80, d[7:0])
		for (int i = 0; i < 3; i++) begin
			rd({4'h0, d[7:0]}, d);
			`CHK("cap id", ids[i], d[7:0])
			`CHK("cap next", nxt[i], d[15:8])
			d = {24'h0, d[15:8]};
		end
	endtask : t_chain

	task automatic t_msi;
		logic [31:0] d;
		for (int i = 0; i < 4; i++)
			wr(`OFS_MSG_IRQ_ADDR_LOW + 12'(4 * i), 32'hC0DE_0000 + 32'(i));
		for (int i = 0; i < 4; i++) begin
			// Message data word keeps only its low half
			rd(`OFS_MSG_IRQ_ADDR_LOW + 12'(4 * i), d);
			`CHK("msi word", (i == 2) ? 32'h0000_0002 : 32'hC0DE_0000 + 32'(i), d)
		end
	endtask : t_msi

	task automatic t_hdr_type;
		logic [31:0] d;
		@(posedge clk) root_port_mode <= 1'b1;
		rd(`OFS_HEADER_MISC, d); `CHK("hdr root", `HDR_TYPE_ROOT_PORT, d[23:16])
		@(posedge clk) root_port_mode <= 1'b0;
		rd(`OFS_HEADER_MISC, d); `CHK("hdr ep", `HDR_TYPE_ENDPOINT, d[23:16])
	endtask : t_hdr_type

	task automatic t_user;
		logic [31:0] d;
		rd(`OFS_USER_EXT_BASE, d); `CHK("user 3dc", 32'h5A5C_33DC, d)
		rd(12'hEFC, d); `CHK("user efc", 32'h5A5C_3EFC, d)
	endtask : t_user

	task automatic t_filter;
		logic [31:0] d;
		msg_beat_t   cq;
		msg_beat_t   pt;
		logic        dr;
		rd(`OFS_ROUTE_MASK, d); `CHK("mask reset", 32'h0003_FFFF, d)
		for (int k = 0; k < 18; k++) begin
			wr(`OFS_ROUTE_MASK, 32'h0003_FFFF & ~(32'h1 << k));
			send(msg_kind_t'(k), cq, pt, dr);
			`CHK("drop", 2'b01, {cq.valid, dr})
			send(msg_kind_t'((k + 1) % 18), cq, pt, dr);
			`CHK("pass", {1'b1, 5'((k + 1) % 18), 1'b0}, {cq.valid, cq.kind, dr})
		end
		rd(`OFS_MSG_COUNT, d); `CHK("drop count", 16'd18, d[15:0])
		wr(`OFS_ROUTE_MASK, 32'h0003_FFFF);
	endtask : t_filter

	task automatic t_port;
		msg_beat_t cq;
		msg_beat_t pt;
		logic      dr;
		wr(`OFS_MODE_CTRL, 32'h0000_0001);
		wr(`OFS_ROUTE_MASK, 32'h0000_0000);
		send(MSG_INT_A, cq, pt, dr);
		`CHK("port", {1'b1, MSG_INT_A, 2'b00}, {pt.valid, pt.kind, cq.valid, dr})
		wr(`OFS_MODE_CTRL, 32'h0000_0000);
		wr(`OFS_ROUTE_MASK, 32'h0003_FFFF);
	endtask : t_port

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		t_header();
		t_chain();
		t_msi();
		t_hdr_type();
		t_user();
		t_filter();
		t_port();
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire

// ===== bench/user_ext_model.sv
// Purpose: User logic serving the extended space handed out by the map
// Assumes: user_ext_rd marks a read taken at that edge
// Notes:   Data stand one cycle only, then change every cycle
`timescale 1ns/1ns
`default_nettype none

module user_ext_model (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Read request from the map
	input  wire logic        user_ext_rd,
	input  wire logic [11:0] reg_addr,
	output logic      [31:0] user_ext_rdata
);
	// ------------------------------------------------------------
	// Answer
	// ------------------------------------------------------------
	// Not kept after the answer cycle: a stale hold would hide late sampling
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			user_ext_rdata <= 32'h0F0F_0F0F;
		else if (user_ext_rd)
			user_ext_rdata <= {20'h5_A5C3, reg_addr};
		else
			user_ext_rdata <= ~user_ext_rdata;
	end
endmodule : user_ext_model

`default_nettype wire

// ===== src/cfg_space_defs.svh
// Purpose: Offsets, field positions, reset values for the config space map
// Assumes: Byte addresses, one aligned 32-bit word per register
// Notes:   Definitions only
`ifndef CFG_SPACE_DEFS_SVH
`define CFG_SPACE_DEFS_SVH

// ----------------------------------------------------------------------
// Header offsets
// ----------------------------------------------------------------------
`define OFS_FUNCTION_IDENTITY  12'h000
`define OFS_STATUS_AND_COMMAND 12'h004
`define OFS_CLASS_AND_REVISION 12'h008
`define OFS_HEADER_MISC        12'h00C
`define OFS_CAP_LIST_POINTER   12'h034
`define OFS_INTERRUPT_PIN_LINE 12'h03C
`define OFS_RESERVED_LO        12'h040
`define OFS_RESERVED_HI        12'h07C
`define OFS_POWER_MGMT_CAPABILITY      12'h080
`define OFS_PM_CTRL_STATUS     12'h084
`define OFS_MSG_IRQ_CONTROL    12'h090
`define OFS_MSG_IRQ_ADDR_LOW   12'h094
`define OFS_MSG_IRQ_ADDR_HIGH  12'h098
`define OFS_MSG_IRQ_DATA       12'h09C
`define OFS_MSG_IRQ_MASK       12'h0A0
`define OFS_MSG_IRQ_PENDING    12'h0A4
`define OFS_EXPRESS_CAP        12'h0C0
`define OFS_USER_EXT_BASE      12'h3DC
`define OFS_ROUTE_MASK         12'hF00
`define OFS_MODE_CTRL          12'hF04
`define OFS_MSG_COUNT          12'hF08

// ----------------------------------------------------------------------
// Capability ids and field values
// ----------------------------------------------------------------------
`define CAP_ID_PM              8'h01
`define CAP_ID_MSG_IRQ         8'h05
`define CAP_ID_EXPRESS         8'h10
`define HDR_TYPE_ENDPOINT      8'h00
`define HDR_TYPE_ROOT_PORT     8'h01
`define CMD_WRITE_MASK         16'h0547
`define POWER_MGMT_CTRL_STATUS_WRITE_MASK       32'h0000_0103
`define MSG_IRQ_CTRL_WMASK     16'h0071
`define ZERO_WORD              32'h0000_0000
`define ROUTE_MASK_RESET       18'h3_FFFF
`define MSG_TYPE_WIDTH         5
`define MSG_KIND_COUNT         18

`endif

// ===== src/cfg_space_pkg.sv
// Purpose: Types shared by the config space map
// Assumes: Constants live in cfg_space_defs.svh
// Notes:   Message kinds follow route mask bit order
package cfg_space_pkg;

	// Route mask bit positions, one kind each
	typedef enum logic [4:0] {
		MSG_ERR_COR      = 5'd0,
		MSG_ERR_NONFATAL = 5'd1,
		MSG_ERR_FATAL    = 5'd2,
		MSG_INT_A        = 5'd3,
		MSG_INT_B        = 5'd4,
		MSG_INT_C        = 5'd5,
		MSG_INT_D        = 5'd6,
		MSG_PM_PME       = 5'd7,
		MSG_PME_TO_ACK   = 5'd8,
		MSG_PME_TURN_OFF = 5'd9,
		MSG_ASPM_NAK     = 5'd10,
		MSG_SLOT_POWER   = 5'd11,
		MSG_LATENCY_TOL  = 5'd12,
		MSG_FLUSH_FILL   = 5'd13,
		MSG_UNLOCK       = 5'd14,
		MSG_VENDOR_0     = 5'd15,
		MSG_VENDOR_1     = 5'd16,
		MSG_PAGE_GROUP   = 5'd17
	} msg_kind_t;

	typedef struct packed {
		logic            valid;
		msg_kind_t       kind;
		logic [31:0]     payload;
	} msg_beat_t;

	typedef struct packed {
		logic            wr;
		logic            rd;
		logic [11:0]     addr;
		logic [31:0]     wdata;
	} cfg_req_t;

endpackage : cfg_space_pkg

// ===== src/msg_route_filter.sv
// Purpose: Steer received messages to the request stream or the message port
// Assumes: One message per cycle, same clock as the map
// Notes:   Outputs registered; one cycle latency
`timescale 1ns/1ns
`default_nettype none
`include "cfg_space_defs.svh"

module msg_route_filter (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// Control
	input  wire logic [17:0]               message_route_mask,
	input  wire logic                      rx_message_port_select,
	// Incoming message
	input  wire cfg_space_pkg::msg_beat_t  msg_in,
	// Outputs
	output var  cfg_space_pkg::msg_beat_t  cq_msg_out,
	output var  cfg_space_pkg::msg_beat_t  port_msg_out,
	output logic                           msg_dropped
);
	import cfg_space_pkg::*;

	// Decoded kind to one-hot mask bit
	function automatic logic [17:0] kind_bit(input msg_kind_t k);
		kind_bit = 18'h0_0001 << k;
	endfunction : kind_bit

	logic pass_cq;
	assign pass_cq = |(kind_bit(msg_in.kind) & message_route_mask);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cq_msg_out   <= '0;
			port_msg_out <= '0;
			msg_dropped  <= 1'b0;
		end else begin
			// Port mode ignores the mask entirely
			port_msg_out       <= msg_in;
			port_msg_out.valid <= msg_in.valid && rx_message_port_select;
			cq_msg_out         <= msg_in;
			cq_msg_out.valid   <= msg_in.valid && !rx_message_port_select && pass_cq;
			msg_dropped        <= msg_in.valid && !rx_message_port_select && !pass_cq;
		end
	end

	chk_filter_pass: assert property (@(posedge clk) disable iff (sys_rst)
		msg_in.valid && !rx_message_port_select && message_route_mask[msg_in.kind]
		|=> cq_msg_out.valid && !port_msg_out.valid)
		else $error("Enabled message not passed");
	chk_filter_drop: assert property (@(posedge clk) disable iff (sys_rst)
		msg_in.valid && !rx_message_port_select && !message_route_mask[msg_in.kind]
		|=> !cq_msg_out.valid && msg_dropped)
		else $error("Masked message not dropped");
	chk_port_mode: assert property (@(posedge clk) disable iff (sys_rst)
		msg_in.valid && rx_message_port_select
		|=> port_msg_out.valid && !cq_msg_out.valid && !msg_dropped)
		else $error("Port mode delivery wrong");
	cov_port_msg: cover property (@(posedge clk) disable iff (sys_rst) port_msg_out.valid);
	cov_drop: cover property (@(posedge clk) disable iff (sys_rst) msg_dropped);

endmodule : msg_route_filter
`default_nettype wire

// ===== src/pcie_config_space_map.sv
// Purpose: Configuration space map with message routing filter
// Assumes: Plain register port, read data one cycle after strobe
// Notes:   Extended space reads from user base below F00h are served by user logic
// How it works
// - Bits 12-16: latency, flush, unlock, vendor
// - Bit 17 gates the page group kind
// - Stream mode: mask one passes, zero drops
// - Port mode: mask ignored, port used
// - Endpoint type 0, root port type 1
// - At most four legacy capabilities
// - At most ten extended capabilities
// - Unimplemented locations outside 3DCh to EFCh read all zeros
// - Identity 000h, command 004h, class 008h
// - Cap pointer 034h, interrupt word 03Ch
// - Message interrupt block 090h to 0A4h
`timescale 1ns/1ns
`default_nettype none
`include "cfg_space_defs.svh"

module pcie_config_space_map #(
	parameter logic [31:0] IDENTITY_WORD  = 32'h0001_0002, // Arbitrary value
	parameter logic [31:0] CLASS_REV_WORD = 32'h0580_0000, // Arbitrary value
	parameter int          LEGACY_CAPS    = 3,
	parameter int          EXT_CAPS       = 1
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// Register port
	input  wire logic [11:0]               reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic [31:0]                    reg_rdata,
	// Mode
	input  wire logic                      root_port_mode,
	// User extended space
	output logic                           user_ext_rd,
	input  wire logic [31:0]               user_ext_rdata,
	// Messages from the link
	input  wire cfg_space_pkg::msg_beat_t  msg_in,
	output var  cfg_space_pkg::msg_beat_t  cq_msg_out,
	output var  cfg_space_pkg::msg_beat_t  port_msg_out,
	output logic                           msg_dropped
);
	import cfg_space_pkg::*;

	// Chain links as full offsets; the low byte is the pointer value
	localparam logic [11:0] PM_CAP_OFS      = `OFS_POWER_MGMT_CAPABILITY;
	localparam logic [11:0] MSG_IRQ_CAP_OFS = `OFS_MSG_IRQ_CONTROL;
	localparam logic [11:0] EXPRESS_CAP_OFS = `OFS_EXPRESS_CAP;

	initial begin
		if (LEGACY_CAPS > 4) $error("Too many legacy capabilities");
		if (EXT_CAPS > 10) $error("Too many extended capabilities");
	end

	// ----------------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------------
	logic [17:0] route_mask_ff;
	logic        port_sel_ff;
	logic [15:0] command_ff;
	logic [7:0]  irq_line_ff;
	logic [7:0]  cache_line_ff;
	logic [31:0] power_mgmt_ctrl_status_ff;
	logic [15:0] msi_ctrl_ff;
	logic [31:0] msi_addr_lo_ff;
	logic [31:0] msi_addr_hi_ff;
	logic [15:0] msi_data_ff;
	logic [31:0] msi_mask_ff;
	logic [31:0] msi_pending_ff;
	logic [15:0] msg_count_ff;

	logic wr_hit;
	assign wr_hit = reg_wr;

	// Bits 0..17 map to kinds in msg_kind_t order
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			route_mask_ff <= `ROUTE_MASK_RESET;
			port_sel_ff   <= 1'b0;
		end else if (wr_hit && reg_addr == `OFS_ROUTE_MASK) begin
			route_mask_ff <= reg_wdata[17:0];
		end else if (wr_hit && reg_addr == `OFS_MODE_CTRL) begin
			port_sel_ff <= reg_wdata[0];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			command_ff    <= 16'h0000;
			irq_line_ff   <= 8'h00;
			cache_line_ff <= 8'h00;
		end else if (wr_hit) begin
			if (reg_addr == `OFS_STATUS_AND_COMMAND) begin
				command_ff <= reg_wdata[15:0] & `CMD_WRITE_MASK;
			end
			if (reg_addr == `OFS_INTERRUPT_PIN_LINE) begin
				irq_line_ff <= reg_wdata[7:0];
			end
			if (reg_addr == `OFS_HEADER_MISC) begin
				cache_line_ff <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_mgmt_ctrl_status_ff <= `ZERO_WORD;
		end else if (wr_hit && reg_addr == `OFS_PM_CTRL_STATUS) begin
			power_mgmt_ctrl_status_ff <= reg_wdata & `POWER_MGMT_CTRL_STATUS_WRITE_MASK;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msi_ctrl_ff    <= 16'h0000;
			msi_addr_lo_ff <= `ZERO_WORD;
			msi_addr_hi_ff <= `ZERO_WORD;
			msi_data_ff    <= 16'h0000;
			msi_mask_ff    <= `ZERO_WORD;
		end else if (wr_hit) begin
			unique case (reg_addr)
				`OFS_MSG_IRQ_CONTROL:   msi_ctrl_ff    <= reg_wdata[31:16] & `MSG_IRQ_CTRL_WMASK;
				`OFS_MSG_IRQ_ADDR_LOW:  msi_addr_lo_ff <= {reg_wdata[31:2], 2'b00};
				`OFS_MSG_IRQ_ADDR_HIGH: msi_addr_hi_ff <= reg_wdata;
				`OFS_MSG_IRQ_DATA:      msi_data_ff    <= reg_wdata[15:0];
				`OFS_MSG_IRQ_MASK:      msi_mask_ff    <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Pending bits are read-only; no source inside the block
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msi_pending_ff <= `ZERO_WORD;
		end else begin
			msi_pending_ff <= msi_pending_ff & msi_mask_ff;
		end
	end

	// ----------------------------------------------------------------------
	// Message filter
	// ----------------------------------------------------------------------
	msg_route_filter u_filter (
		.clk                    (clk),
		.sys_rst                (sys_rst),
		.message_route_mask     (route_mask_ff),
		.rx_message_port_select (port_sel_ff),
		.msg_in                 (msg_in),
		.cq_msg_out             (cq_msg_out),
		.port_msg_out           (port_msg_out),
		.msg_dropped            (msg_dropped)
	);

	// Saturating count of filtered messages, visible to software
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			msg_count_ff <= 16'h0000;
		end else if (msg_dropped && msg_count_ff != 16'hFFFF) begin
			msg_count_ff <= msg_count_ff + 16'h0001;
		end
	end

	// ----------------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------------
	// Capability chain: 034h -> PM 080h -> message irq 090h -> express 0C0h -> 0
	function automatic logic [31:0] read_word(input logic [11:0] a);
		logic [7:0] htype;
		htype = root_port_mode ? `HDR_TYPE_ROOT_PORT : `HDR_TYPE_ENDPOINT;
		unique case (a)
			`OFS_FUNCTION_IDENTITY:  read_word = IDENTITY_WORD;
			`OFS_STATUS_AND_COMMAND: read_word = {16'h0010, command_ff};
			`OFS_CLASS_AND_REVISION: read_word = CLASS_REV_WORD;
			`OFS_HEADER_MISC:        read_word = {8'h00, htype, 8'h00, cache_line_ff};
			`OFS_CAP_LIST_POINTER:   read_word = {24'h00_0000, PM_CAP_OFS[7:0]};
			`OFS_INTERRUPT_PIN_LINE: read_word = {16'h0000, 8'h01, irq_line_ff};
			`OFS_POWER_MGMT_CAPABILITY:      read_word = {16'h0003, MSG_IRQ_CAP_OFS[7:0], `CAP_ID_PM};
			`OFS_PM_CTRL_STATUS:     read_word = power_mgmt_ctrl_status_ff;
			`OFS_MSG_IRQ_CONTROL:    read_word = {msi_ctrl_ff | 16'h0180, EXPRESS_CAP_OFS[7:0], `CAP_ID_MSG_IRQ};
			`OFS_MSG_IRQ_ADDR_LOW:   read_word = msi_addr_lo_ff;
			`OFS_MSG_IRQ_ADDR_HIGH:  read_word = msi_addr_hi_ff;
			`OFS_MSG_IRQ_DATA:       read_word = {16'h0000, msi_data_ff};
			`OFS_MSG_IRQ_MASK:       read_word = msi_mask_ff;
			`OFS_MSG_IRQ_PENDING:    read_word = msi_pending_ff;
			`OFS_EXPRESS_CAP:        read_word = {16'h0002 | (root_port_mode ? 16'h0040 : 16'h0000),
				8'h00, `CAP_ID_EXPRESS};
			`OFS_ROUTE_MASK:         read_word = {14'h0000, route_mask_ff};
			`OFS_MODE_CTRL:          read_word = {31'h0000_0000, port_sel_ff};
			`OFS_MSG_COUNT:          read_word = {16'h0000, msg_count_ff};
			default:                 read_word = `ZERO_WORD;
		endcase
	endfunction : read_word

	logic user_zone;
	assign user_zone = (reg_addr >= `OFS_USER_EXT_BASE) && (reg_addr < `OFS_ROUTE_MASK);
	assign user_ext_rd = reg_rd && user_zone;

	logic user_sel_ff;
	logic [31:0] rdata_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_ff    <= `ZERO_WORD;
			user_sel_ff <= 1'b0;
		end else begin
			user_sel_ff <= reg_rd && user_zone;
			rdata_ff    <= reg_rd && !user_zone ? read_word(reg_addr) : `ZERO_WORD;
		end
	end

	// User logic answers in the cycle after its strobe
	assign reg_rdata = user_sel_ff ? user_ext_rdata : rdata_ff;

	// ----------------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------------
	chk_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr >= `OFS_RESERVED_LO && reg_addr <= `OFS_RESERVED_HI
		|=> reg_rdata == `ZERO_WORD)
		else $error("Reserved location not zero");
	chk_hdr_type: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == `OFS_HEADER_MISC
		|=> reg_rdata[23:16] == ($past(root_port_mode) ? 8'h01 : 8'h00))
		else $error("Header type mismatch");
	chk_cap_chain: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == `OFS_CAP_LIST_POINTER |=> reg_rdata == 32'h0000_0080)
		else $error("Capability pointer wrong");
	chk_chain_end: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == `OFS_EXPRESS_CAP |=> reg_rdata[15:8] == 8'h00)
		else $error("Chain not terminated");
	chk_msi_roundtrip: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `OFS_MSG_IRQ_MASK ##1 reg_rd && reg_addr == `OFS_MSG_IRQ_MASK
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("Mask bits not stored");
	chk_mask_update: assert property (@(posedge clk) disable iff (sys_rst)
		reg_wr && reg_addr == `OFS_ROUTE_MASK |=> route_mask_ff == $past(reg_wdata[17:0]))
		else $error("Route mask not written");
	chk_user_fwd: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == `OFS_USER_EXT_BASE |-> user_ext_rd ##1 reg_rdata == user_ext_rdata)
		else $error("User space not forwarded");
	chk_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == 12'h0A8 |=> reg_rdata == `ZERO_WORD)
		else $error("Unimplemented word not zero");
	cov_cfg_read: cover property (@(posedge clk) disable iff (sys_rst) reg_rd ##1 reg_rd);
	cov_user_read: cover property (@(posedge clk) disable iff (sys_rst) user_ext_rd);
	cov_cq_msg: cover property (@(posedge clk) disable iff (sys_rst) cq_msg_out.valid);

endmodule : pcie_config_space_map
`default_nettype wire
